// ==== rtl/kis_scanner.v ====
`timescale 1ns/100ps
`default_nettype none
`include "kis_consts.vh"

// Functional notes
// - Controller interrupt reacts to falling edges only, one per edge.
// - Accepted interrupt aborts measurement; cycle restarts after handling.
// - Detector drives interrupt line low while any key closed.
// - Interrupt stage held asserted at least 50 ms after key activity.
// - Interrupt starts key scan at once; key found before release.
// - Scan starts with enable 2 and select F, first row.
// - Low select bits pick output; bit2 picks half; enable gates both.
// - Row outputs open-collector; only the selected row pulled low.
// - Select bit3 high enables first column group readback only.
// - Selected gates pass columns uninverted; bit3 low reads second group.
// - Idle columns read F; highest numbered decoded bit has priority.
// - Rows step down; at select 7 second column group is read.
// - Rescan until 50 ms, then resume; always start new cycle.
module kis_scanner #(
   parameter HOLD_CYC = `KIS_HOLD_CYC,
   parameter SCAN_CYC = `KIS_SCAN_CYC,
   parameter ROWS = 8,
   parameter COLS = 8
) (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Key matrix
   input wire [COLS-1:0] col_in,
   output reg [ROWS-1:0] row_out_ff,
   output reg [ROWS-1:0] row_oe_ff,
   // Detector line and bus code word
   output reg external_interrupt_line_ff,
   output reg [3:0] bus_enable_ff,
   output reg [3:0] bus_select_ff,
   output reg [3:0] bus_data_ff,
   // Controller status
   output reg meas_abort_ff,
   output reg cycle_restart_ff,
   output reg key_valid_ff,
   output reg [5:0] key_code_ff,
   output reg scanning_ff
);

   localparam ST_IDLE = 2'b00;
   localparam ST_STEP = 2'b01;
   localparam ST_READ = 2'b10;
   localparam ST_DONE = 2'b11;
   // Last settle cycle, compared at full width to avoid truncation
   localparam [31:0] STEP_LAST = `KIS_STEP_CYC - 1;

   wire any_key;
   wire int_n;
   reg int_n_d_ff;
   reg [1:0] state_ff;
   reg [31:0] scan_cnt_ff;
   reg [2:0] step_cnt_ff;
   reg [3:0] d_lines;
   integer i;

   // Row decode: select bits 1:0 pick output, bit 2 picks half
   function [ROWS-1:0] row_decode;
      input [3:0] en;
      input [3:0] sel;
      begin
         row_decode = {ROWS{1'b0}};
         if (en == `KIS_ENABLE_KEYS) begin
            row_decode[{~sel[`KIS_SEL_HALF_BIT], sel[1:0]}] = 1'b1;
         end
      end
   endfunction

   // Key sense: selected row low makes closed column low
   assign any_key = |(~col_in) | 1'b0;

   kis_detector #(
      .HOLD_CYC(HOLD_CYC)
   ) u_det (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .any_key(any_key),
      .int_drive_n_ff(int_n)
   );

   // Readback gates: columns pass uninverted, select bit 3 picks low or high group
   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         if (bus_select_ff[`KIS_SEL_GROUP_BIT]) begin
            d_lines[i] = ~(~col_in[i]);
         end else begin
            d_lines[i] = ~(~col_in[i+4]);
         end
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         int_n_d_ff <= 1'b1;
         state_ff <= ST_IDLE;
         scan_cnt_ff <= 32'h00000000;
         step_cnt_ff <= 3'h0;
         row_out_ff <= {ROWS{1'b0}};
         row_oe_ff <= {ROWS{1'b0}};
         external_interrupt_line_ff <= 1'b1;
         bus_enable_ff <= 4'h0;
         bus_select_ff <= 4'h0;
         bus_data_ff <= `KIS_DATA_IDLE;
         meas_abort_ff <= 1'b0;
         cycle_restart_ff <= 1'b0;
         key_valid_ff <= 1'b0;
         key_code_ff <= 6'h00;
         scanning_ff <= 1'b0;
      end else begin
         int_n_d_ff <= int_n;
         external_interrupt_line_ff <= int_n;
         meas_abort_ff <= 1'b0;
         cycle_restart_ff <= 1'b0;
         key_valid_ff <= 1'b0;
         row_out_ff <= {ROWS{1'b0}};
         row_oe_ff <= row_decode(bus_enable_ff, bus_select_ff);
         bus_data_ff <= d_lines;
         case (state_ff)
            ST_IDLE: begin
               // Falling edge only; a stuck low line fires once
               if (int_n_d_ff && !int_n) begin
                  meas_abort_ff <= 1'b1;
                  bus_enable_ff <= `KIS_ENABLE_KEYS;
                  bus_select_ff <= `KIS_SEL_FIRST;
                  scan_cnt_ff <= 32'h00000000;
                  step_cnt_ff <= 3'h0;
                  scanning_ff <= 1'b1;
                  state_ff <= ST_STEP;
               end
            end
            ST_STEP: begin
               // Wait for row and gates to settle
               scan_cnt_ff <= scan_cnt_ff + 32'h00000001;
               step_cnt_ff <= step_cnt_ff + 3'h1;
               if ({29'h00000000, step_cnt_ff} == STEP_LAST) begin
                  state_ff <= ST_READ;
               end
            end
            ST_READ: begin
               scan_cnt_ff <= scan_cnt_ff + 32'h00000001;
               step_cnt_ff <= 3'h0;
               if (d_lines != `KIS_DATA_IDLE) begin
                  key_valid_ff <= 1'b1;
                  key_code_ff[5:2] <= bus_select_ff;
                  // Highest decoded bit wins
                  if (!d_lines[3]) key_code_ff[1:0] <= 2'd3;
                  else if (!d_lines[2]) key_code_ff[1:0] <= 2'd2;
                  else if (!d_lines[1]) key_code_ff[1:0] <= 2'd1;
                  else key_code_ff[1:0] <= 2'd0;
                  state_ff <= ST_DONE;
               end else if (scan_cnt_ff >= SCAN_CYC) begin
                  state_ff <= ST_DONE;
               end else begin
                  // Step rows F..8; at 7 switch group and restart rows
                  if (bus_select_ff == 4'h0) begin
                     bus_select_ff <= `KIS_SEL_FIRST;
                  end else begin
                     bus_select_ff <= bus_select_ff - 4'h1;
                  end
                  state_ff <= ST_STEP;
               end
            end
            ST_DONE: begin
               bus_enable_ff <= 4'h0;
               scanning_ff <= 1'b0;
               cycle_restart_ff <= 1'b1;
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== rtl/kis_consts.vh ====
`ifndef KIS_CONSTS_VH
`define KIS_CONSTS_VH

// Clock and timing
`define KIS_CLK_MHZ 200
`define KIS_HOLD_MS 50
`define KIS_HOLD_CYC (`KIS_HOLD_MS * 1000 * `KIS_CLK_MHZ)
`define KIS_SCAN_MS 50
`define KIS_SCAN_CYC (`KIS_SCAN_MS * 1000 * `KIS_CLK_MHZ)
`define KIS_STEP_CYC 4

// Bus code word fields
`define KIS_ENABLE_KEYS 4'h2
`define KIS_SEL_FIRST 4'hF
`define KIS_SEL_SWITCH 4'h7
`define KIS_SEL_HALF_BIT 2
`define KIS_SEL_GROUP_BIT 3
`define KIS_DATA_IDLE 4'hF

`endif

// ==== rtl/kis_detector.v ====
`timescale 1ns/100ps
`default_nettype none
`include "kis_consts.vh"

module kis_detector #(
   parameter HOLD_CYC = `KIS_HOLD_CYC
) (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Key activity
   input wire any_key,
   // Interrupt stage, active low
   output reg int_drive_n_ff
);

   reg [31:0] hold_cnt_ff;
   reg [31:0] nxt_hold_cnt;

   always @* begin
      nxt_hold_cnt = hold_cnt_ff;
      if (any_key) begin
         nxt_hold_cnt = HOLD_CYC;
      end else if (hold_cnt_ff != 32'h00000000) begin
         nxt_hold_cnt = hold_cnt_ff - 32'h00000001;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         hold_cnt_ff <= 32'h00000000;
         int_drive_n_ff <= 1'b1;
      end else begin
         hold_cnt_ff <= nxt_hold_cnt;
         // Low while any key closed or hold running
         int_drive_n_ff <= ~(any_key | (nxt_hold_cnt != 32'h00000000));
      end
   end

endmodule
`default_nettype wire

// ==== dv/kis_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module kis_monitor (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Matrix side
   input wire [7:0] col_in,
   input wire [7:0] row_out_ff,
   input wire [7:0] row_oe_ff,
   // Controller side
   input wire external_interrupt_line_ff,
   input wire [3:0] bus_enable_ff,
   input wire [3:0] bus_select_ff,
   input wire meas_abort_ff,
   input wire cycle_restart_ff,
   input wire scanning_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence scan_go; $rose(scanning_ff); endsequence
   sequence scan_end; ##[1:1000] !scanning_ff; endsequence
   row_onehot_a: assert property ($onehot0(row_oe_ff))
      else $error("more than one row driven");
   row_low_a: assert property (row_out_ff == 8'h00)
      else $error("row data not low");
   row_pick_a: assert property (row_oe_ff != 8'h00 |-> row_oe_ff ==
      8'h01 << {~$past(bus_select_ff[2]), $past(bus_select_ff[1:0])})
      else $error("wrong row for select");
   scan_code_a: assert property (scanning_ff |-> bus_enable_ff == 4'h2)
      else $error("enable not 2 in scan");
   first_row_a: assert property (scan_go |-> bus_select_ff == 4'hF)
      else $error("scan not started at F");
   key_int_a: assert property (!scanning_ff && col_in != 8'hFF
      |-> ##[1:2] !external_interrupt_line_ff)
      else $error("no interrupt on key");
   scan_limit_a: assert property (scan_go |-> scan_end)
      else $error("scan too long");
   abort_pulse_a: assert property (meas_abort_ff |=> !meas_abort_ff)
      else $error("abort longer than one cycle");
   restart_once_a: assert property (cycle_restart_ff |=> !scanning_ff)
      else $error("scan runs past restart");
endmodule
bind kis_scanner kis_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
   .col_in(col_in), .row_out_ff(row_out_ff), .row_oe_ff(row_oe_ff),
   .external_interrupt_line_ff(external_interrupt_line_ff),
   .bus_enable_ff(bus_enable_ff), .bus_select_ff(bus_select_ff),
   .meas_abort_ff(meas_abort_ff), .cycle_restart_ff(cycle_restart_ff),
   .scanning_ff(scanning_ff));
`default_nettype wire

// ==== dv/kis_key_matrix.sv ====
`timescale 1ns/100ps
`default_nettype none
module kis_key_matrix (
   // Row pulls from scanner
   input wire logic [7:0] row_oe,
   // One key switch
   input wire logic pressed,
   input wire logic [2:0] key_row,
   input wire logic [2:0] key_col,
   // Column lines
   output var logic [7:0] col_in
);
   // Idle rows let a closed key reach the detector
   always_comb begin
      col_in = 8'hFF;
      if (pressed && (row_oe == 8'h00 || row_oe[key_row])) begin
         col_in[key_col] = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== dv/keyboard_interrupt_scanner_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module keyboard_interrupt_scanner_test;
   logic core_clk = 0, sys_rst = 1, pressed = 0;
   logic [2:0] key_row = 0, key_col = 0;
   logic [23:0] keys = 24'o21567700;
   wire [7:0] col_in, row_out, row_oe;
   wire external_interrupt_line, abort, restart, valid, scanning;
   wire [3:0] en, sel, dat;
   wire [5:0] code;
   int mismatches = 0, num_checks = 0, cycles = 0, aborts = 0, a0;
   always #2.5 core_clk = ~core_clk;
   kis_key_matrix u_keys (.row_oe(row_oe), .pressed(pressed),
      .key_row(key_row), .key_col(key_col), .col_in(col_in));
   kis_scanner #(.HOLD_CYC(20), .SCAN_CYC(200)) u_dut (.core_clk(core_clk),
      .sys_rst(sys_rst), .col_in(col_in), .row_out_ff(row_out),
      .row_oe_ff(row_oe), .external_interrupt_line_ff(external_interrupt_line),
      .bus_enable_ff(en), .bus_select_ff(sel), .bus_data_ff(dat),
      .meas_abort_ff(abort), .cycle_restart_ff(restart),
      .key_valid_ff(valid), .key_code_ff(code), .scanning_ff(scanning));
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [7:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task run_key(input logic [2:0] r, c);
      int n;
      a0 = aborts;
      key_row = r;
      key_col = c;
      pressed = 1;
      for (n = 0; n < 400 && valid !== 1'b1; n++) tick(1);
      chk("code", {c < 3'h4, ~r[2], r[1:0], c[1:0]}, code);
      chk("line", 8'h00, external_interrupt_line);
      tick(40);
      // Held key is one edge, so only one scan may follow
      chk("aborts", 8'h01, 8'(aborts - a0));
      pressed = 0;
      tick(10);
      chk("hold", 8'h00, external_interrupt_line);
      tick(30);
      chk("free", 8'h01, external_interrupt_line);
      $display("key test %0d %0d done", r, c);
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (abort === 1'b1) aborts <= aborts + 1;
      if (cycles == 6000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      tick(10);
      sys_rst = 0;
      tick(1);
      chk("idle line", 8'h01, external_interrupt_line);
      chk("idle data", 8'h0F, dat);
      $display("reset test done");
      for (int i = 0; i < 4; i++) run_key(keys[6*i+3 +: 3], keys[6*i +: 3]);
      give_verdict();
   end
endmodule
`default_nettype wire
